// >>> common/pga_consts.svh
`ifndef PGA_CONSTS_SVH
`define PGA_CONSTS_SVH
// register indices on the plain port
`define PGA_REG4_IDX        3'h4
`define PGA_REG5_IDX        3'h5
`define PGA_MODE_IDX        3'h6
// sub-register selector in bits 7:6
`define PGA_SEL_ADC         2'h0
`define PGA_SEL_DAC         2'h1
`define PGA_SEL_5C          2'h2
`define PGA_SEL_5D          2'h3
// gain codes
`define PGA_GAIN_RST        6'h2A
`define PGA_GAIN_MUTE       6'h3F
`define PGA_GAIN_MAX_DB     8'h14
`define PGA_GAIN_MIN_DB     8'hD6
// divider defaults: m and n stored as written codes
`define PGA_M_RST           7'h10
`define PGA_N_RST           4'h6
`define PGA_P_RST           3'h0
`define PGA_P_COARSE        3'h0
`define PGA_SIDE_RST        6'h38
`define PGA_5D_RST          6'h00
// divider update waits this many sampling periods
`define PGA_UPD_PERIODS     2'h2
`endif

// >>> common/pga_pkg.sv
package pga_pkg;
    typedef struct packed {
        logic [6:0] m_code;
        logic [3:0] n_code;
        logic [2:0] p_code;
    } pga_div_t;

    typedef struct packed {
        logic       mute;
        logic [7:0] gain_db;
    } pga_gain_t;
endpackage

// >>> hdl/pga_regs.sv
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "pga_consts.svh"
// Functional notes
// - dividers reset to M16, N6, P8
// - P equal eight selects coarse sampling
// - new dividers apply after two sample periods
// - top bits 00 select ADC gain
// - ADC gain six bits, reset 101010
// - DAC gain, selector 01, same reset
// - reads cycle ADC, DAC, 5C, 5D
// - default code means 0 dB
// - all-ones ADC code mutes
// - code 62 is 20 dB, 1 dB steps
// - code zero is minus 42 dB
module pga_regs
(
    input  wire logic                    clock_i,
    input  wire logic                    sys_rst_i,
    input  wire logic [2:0]              addr_i,
    input  wire logic [7:0]              wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    input  wire logic                    sample_tick_i,
    output logic      [7:0]              rdata_o,
    output pga_pkg::pga_div_t            div_o,
    output logic                         coarse_o,
    output pga_pkg::pga_gain_t           adc_gain_o,
    output logic      [5:0]              dac_gain_code_o
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic pga_pkg::pga_gain_t gain_of(input logic [5:0] code);
        pga_pkg::pga_gain_t g;
        // the mute code still yields a level; users must test mute first
        g.mute    = (code == `PGA_GAIN_MUTE);
        // code 0 is -42 dB, one dB per step up to 62 -> 20 dB
        g.gain_db = `PGA_GAIN_MIN_DB + {2'h0, code};
        return g;
    endfunction

    // whole-register strobes only; the port has no byte lanes
    logic                 w4;
    logic                 w5;
    assign w4 = wr_i && (addr_i == `PGA_REG4_IDX);
    assign w5 = wr_i && (addr_i == `PGA_REG5_IDX);

    // ------------------------------------------------------------
    // gain sub-registers
    // ------------------------------------------------------------
    // selector bits are not stored: reads rebuild them from the pointer
    logic [5:0]           adc_gain_code_ff;
    logic [5:0]           dac_gain_code_ff;
    logic [5:0]           side_ff;
    logic [5:0]           sub5d_ff;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            adc_gain_code_ff <= `PGA_GAIN_RST;
            dac_gain_code_ff <= `PGA_GAIN_RST;
            side_ff          <= `PGA_SIDE_RST;
            sub5d_ff         <= `PGA_5D_RST;
        end
        else if (w5)
        begin
            // 5C and 5D fields belong to other blocks; kept here as plain bits
            unique case (wdata_i[7:6])
                `PGA_SEL_ADC: adc_gain_code_ff <= wdata_i[5:0];
                `PGA_SEL_DAC: dac_gain_code_ff <= wdata_i[5:0];
                `PGA_SEL_5C:  side_ff          <= wdata_i[5:0];
                `PGA_SEL_5D:  sub5d_ff         <= wdata_i[5:0];
            endcase
        end
    end

    // ------------------------------------------------------------
    // dividers: pending set, applied after two sample ticks
    // ------------------------------------------------------------
    pga_pkg::pga_div_t    pend_ff;
    pga_pkg::pga_div_t    div_ff;
    logic [1:0]           upd_cnt_ff;
    logic                 upd_busy_ff;
    logic                 upd_apply;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            pend_ff.m_code <= `PGA_M_RST;
            pend_ff.n_code <= `PGA_N_RST;
            pend_ff.p_code <= `PGA_P_RST;
        end
        else if (w4)
        begin
            if (wdata_i[7])
                pend_ff.m_code <= wdata_i[6:0];
            else
            begin
                pend_ff.n_code <= wdata_i[6:3];
                pend_ff.p_code <= wdata_i[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // update timing
    // ------------------------------------------------------------
    // the set applies on the tick that completes the wait
    assign upd_apply = upd_busy_ff && sample_tick_i
                       && (upd_cnt_ff == `PGA_UPD_PERIODS - 2'h1);

    // a write restarts the wait; one landing on the completing tick still lets the set pending before it apply
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            upd_busy_ff <= 1'b0;
            upd_cnt_ff  <= 2'h0;
        end
        else if (w4)
        begin
            upd_busy_ff <= 1'b1;
            upd_cnt_ff  <= 2'h0;
        end
        else if (upd_busy_ff && sample_tick_i)
        begin
            upd_cnt_ff <= upd_cnt_ff + 2'h1;
            if (upd_apply)
                upd_busy_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            div_ff.m_code <= `PGA_M_RST;
            div_ff.n_code <= `PGA_N_RST;
            div_ff.p_code <= `PGA_P_RST;
        end
        else if (upd_apply)
            div_ff <= pend_ff;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            // outputs carry the divider reset set from the first cycle on
            div_o.m_code    <= `PGA_M_RST;
            div_o.n_code    <= `PGA_N_RST;
            div_o.p_code    <= `PGA_P_RST;
            coarse_o        <= 1'b1;
            adc_gain_o      <= '0;
            dac_gain_code_o <= `PGA_GAIN_RST;
        end
        else
        begin
            div_o           <= div_ff;
            // p code 0 stands for a divider of eight
            coarse_o        <= (div_ff.p_code == `PGA_P_COARSE);
            adc_gain_o      <= gain_of(adc_gain_code_ff);
            dac_gain_code_o <= dac_gain_code_ff;
        end
    end

    // ------------------------------------------------------------
    // read port, with rotating pointers for registers 4 and 5
    // ------------------------------------------------------------
    // the pointer moves on every read of register five; software that loses
    // count reads until the selector field shows the ADC code again
    logic [1:0]           rd5_ptr_ff;
    logic                 rd4_ptr_ff;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            rd5_ptr_ff <= 2'h0;
            rd4_ptr_ff <= 1'b0;
        end
        else if (rd_i)
        begin
            if (addr_i == `PGA_REG5_IDX)
                rd5_ptr_ff <= rd5_ptr_ff + 2'h1;
            if (addr_i == `PGA_REG4_IDX)
                rd4_ptr_ff <= ~rd4_ptr_ff;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
        begin
            unique case (addr_i)
                `PGA_REG4_IDX: rdata_o <= rd4_ptr_ff ? {1'b1, pend_ff.m_code}
                                         : {1'b0, pend_ff.n_code, pend_ff.p_code};
                `PGA_REG5_IDX:
                begin
                    unique case (rd5_ptr_ff)
                        `PGA_SEL_ADC: rdata_o <= {`PGA_SEL_ADC, adc_gain_code_ff};
                        `PGA_SEL_DAC: rdata_o <= {`PGA_SEL_DAC, dac_gain_code_ff};
                        `PGA_SEL_5C:  rdata_o <= {`PGA_SEL_5C, side_ff};
                        `PGA_SEL_5D:  rdata_o <= {`PGA_SEL_5D, sub5d_ff};
                    endcase
                end
                `PGA_MODE_IDX: rdata_o <= {6'h00, upd_busy_ff, coarse_o};
                default:       rdata_o <= 8'h00;
            endcase
        end
        else
            // data stand for one cycle only; idle cycles read as zero
            rdata_o <= 8'h00;
    end

endmodule

// >>> test/pga_tick_gen.sv
`timescale 1ns/1ps
// codec core stand-in: one sampling tick every PERIOD clocks
module pga_tick_gen
#(
    parameter int PERIOD = 16
)
(
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    output logic      tick_o
);
    logic [7:0] cnt_ff;
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || tick_o)
            cnt_ff <= 8'h00;
        else
            cnt_ff <= cnt_ff + 8'h01;
    end
    assign tick_o = !sys_rst_i && (cnt_ff == 8'(PERIOD - 1));
endmodule

// >>> test/pga_regs_props.sv
`timescale 1ns/1ps
module pga_regs_props
(
    input wire logic               clock_i,
    input wire logic               sys_rst_i,
    input wire logic [2:0]         addr_i,
    input wire logic [7:0]         wdata_i,
    input wire logic               wr_i,
    input wire logic               rd_i,
    input wire logic               sample_tick_i,
    input wire logic [7:0]         rdata_o,
    input wire pga_pkg::pga_div_t  div_o,
    input wire logic               coarse_o,
    input wire pga_pkg::pga_gain_t adc_gain_o,
    input wire logic [5:0]         dac_gain_code_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic [1:0] sel_q;
    logic [2:0] quiet_q;
    always_ff @(posedge clock_i)
        sel_q <= rdata_o[7:6];
    // the divider outputs may only move shortly after a sampling tick
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || sample_tick_i)
            quiet_q <= 3'h0;
        else if (quiet_q != 3'h7)
            quiet_q <= quiet_q + 3'h1;
    end
    sequence s_rd5;
        rd_i && addr_i == 3'h5;
    endsequence
    property p_adc;
        logic [5:0] c;
        (wr_i && addr_i == 3'h5 && wdata_i[7:6] == 2'h0, c = wdata_i[5:0]) |-> ##2
        adc_gain_o.mute == (c == 6'h3F) && (c == 6'h3F || adc_gain_o.gain_db == {2'h0, c} - 8'h2A);
    endproperty
    property p_dac;
        logic [5:0] c;
        (wr_i && addr_i == 3'h5 && wdata_i[7:6] == 2'h1, c = wdata_i[5:0]) |-> ##2 dac_gain_code_o == c;
    endproperty
    adc_gain_map_a: assert property (p_adc) else $error("adc gain mismatch");
    dac_gain_map_a: assert property (p_dac) else $error("dac gain mismatch");
    adc_gain_keep_a: assert property (wr_i && addr_i == 3'h5 && wdata_i[7:6] != 2'h0
        |-> ##2 $stable(adc_gain_o)) else $error("adc gain moved");
    dac_gain_keep_a: assert property (wr_i && addr_i == 3'h5 && wdata_i[7:6] != 2'h1
        |-> ##2 $stable(dac_gain_code_o)) else $error("dac gain moved");
    coarse_mode_a: assert property ($stable(div_o) |-> coarse_o == (div_o.p_code == 3'h0))
        else $error("coarse flag mismatch");
    read_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("stray read data");
    read_rotate_a: assert property (s_rd5 ##1 s_rd5 |=> rdata_o[7:6] == sel_q + 2'h1)
        else $error("read order broken");
    div_hold_a: assert property (quiet_q > 3'h3 |-> $stable(div_o)) else $error("divider moved");
endmodule
bind pga_regs pga_regs_props u_props (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .sample_tick_i, .rdata_o, .div_o, .coarse_o, .adc_gain_o, .dac_gain_code_o);

// >>> test/test_adc_pga_gain_register.sv
`timescale 1ns/1ps
module test_adc_pga_gain_register;
    logic               clock_i, sys_rst_i, wr_i, rd_i, tick, coarse_o;
    logic [2:0]         addr_i;
    logic [7:0]         wdata_i, rdata_o;
    logic [5:0]         dac_gain_code_o;
    pga_pkg::pga_div_t  div_o;
    pga_pkg::pga_gain_t adc_gain_o;
    int                 err_total, n_checks, cyc;
    pga_regs u_dut (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .sample_tick_i(tick),
        .rdata_o, .div_o, .coarse_o, .adc_gain_o, .dac_gain_code_o);
    pga_tick_gen #(.PERIOD(16)) u_tick (.clock_i, .sys_rst_i, .tick_o(tick));
    //----------------------------------------
    // check, bus and report tasks
    //----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // returns once the gain outputs of the write have landed
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    // n reads back to back, rdata checked in the cycle after each
    task automatic rd(input logic [2:0] a, input int n, input logic [7:0] e [4]);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clock_i);
            if (i == n - 1)
                rd_i <= 1'b0;
            #1;
            chk({8'h00, rdata_o}, {8'h00, e[i]});
        end
    endtask
    task automatic final_report();
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    //----------------------------------------
    // clock, timeout, tests
    //----------------------------------------
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            final_report();
        end
    end
    initial
    begin
        {sys_rst_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 13'h0000};
        {err_total, n_checks, cyc} = '0;
        repeat (8) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd(3'h5, 4, '{8'h2A, 8'h6A, 8'hB8, 8'hC0});
        chk({2'h0, div_o}, {2'h0, 7'h10, 4'h6, 3'h0});
        chk({15'h0, coarse_o}, 16'h0001);
        chk({7'h0, adc_gain_o}, 16'h0000);
        chk({10'h0, dac_gain_code_o}, 16'h002A);
        wr(3'h5, 8'h3F);
        chk({15'h0, adc_gain_o.mute}, 16'h0001);
        wr(3'h5, 8'h3E);
        chk({7'h0, adc_gain_o}, 16'h0014);
        wr(3'h5, 8'h3D);
        chk({7'h0, adc_gain_o}, 16'h0013);
        wr(3'h5, 8'h00);
        chk({7'h0, adc_gain_o}, 16'h00D6);
        wr(3'h5, 8'h55);
        wr(3'h5, 8'hA0);
        wr(3'h5, 8'hFF);
        chk({7'h0, adc_gain_o}, 16'h00D6);
        chk({10'h0, dac_gain_code_o}, 16'h0015);
        rd(3'h5, 4, '{8'h00, 8'h55, 8'hA0, 8'hFF});
        // align the divider write to a tick so the two counted ticks are known
        @(posedge clock_i iff tick);
        wr(3'h4, 8'h01);
        chk({1'b0, coarse_o, div_o}, {2'h1, 7'h10, 4'h6, 3'h0});
        @(posedge clock_i iff tick);
        repeat (2) @(posedge clock_i);
        #1;
        chk({1'b0, coarse_o, div_o}, {2'h1, 7'h10, 4'h6, 3'h0});
        rd(3'h6, 1, '{8'h03, 8'h00, 8'h00, 8'h00});
        repeat (40) @(posedge clock_i);
        #1;
        chk({1'b0, coarse_o, div_o}, {2'h0, 7'h10, 4'h0, 3'h1});
        rd(3'h6, 1, '{8'h00, 8'h00, 8'h00, 8'h00});
        rd(3'h4, 2, '{8'h01, 8'h90, 8'h00, 8'h00});
        rd(3'h7, 1, '{8'h00, 8'h00, 8'h00, 8'h00});
        final_report();
    end
endmodule
